/* File: hdl/alpg_map.svh */
// Register map of the alarm pin configuration and write-guard block.
// Assumes 8-bit registers addressed by a 7-bit serial-port register address.
`ifndef ALPG_MAP_SVH
`define ALPG_MAP_SVH

// ==========================================================================
// Offsets
`define ALPG_LOSS_ALARM_PIN_CONFIG_ADDR 7'h7d
`define ALPG_WRITE_GUARD_ADDR 7'h7e

// ==========================================================================
// Reset values
`define ALPG_LOSS_ALARM_PIN_CONFIG_RST 8'h02
`define ALPG_WRITE_GUARD_RST 8'h85

// ==========================================================================
// Field positions of the alarm pin configuration register
`define ALPG_ACTIVE_LEVEL_BIT 0
`define ALPG_FLOAT_IDLE_BIT 1
`define ALPG_GPO_SELECT_BIT 2
`define ALPG_CFG_USED_MASK 8'h07

// ==========================================================================
// Write-guard codes
`define ALPG_GUARD_OPEN 8'h85
`define ALPG_GUARD_SINGLE 8'h86
`define ALPG_GUARD_RELOCK 8'h87

// ==========================================================================
// Reset and idle values of the outputs
`define ALPG_RDATA_RST 8'h00
`define ALPG_UNMAPPED_RDATA 8'h00
`define ALPG_PIN_LEVEL_RST 1'b0
`define ALPG_PIN_OE_RST 1'b0

`endif

/* File: hdl/alpg_pkg.sv */
// Types shared by the alarm pin configuration and write-guard block.
// Assumes the map header is included by the files that need offsets.
package alpg_pkg;

  // ========================================================================
  // Protection modes decoded from the write-guard code
  typedef enum logic [1:0] {
    ALPG_PROTECTED,
    ALPG_UNPROTECTED,
    ALPG_SINGLE_WRITE
  } alpg_mode_type;

endpackage

/* File: hdl/alpg_top.sv */
// Alarm pin configuration register, software write-guard and alarm pin driver.
// Assumes the serial port front end presents one register access per cycle on clk,
// and that alarm_active and gpo_level come from logic on the same clock.
`include "alpg_map.svh"

module alpg_top #(
  parameter int ADDR_W = 7
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register access from the serial port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Gated write to the rest of the device's registers
  output logic other_wr,
  output logic [ADDR_W-1:0] other_addr,
  output logic [7:0] other_wdata,
  // Alarm source and general purpose level
  input wire logic alarm_active,
  input wire logic gpo_level,
  // Alarm pin, three-state
  output logic loss_alarm_pin,
  output logic loss_alarm_pin_oe,
  // Decoded protection state
  output alpg_pkg::alpg_mode_type guard_mode
);

  // ========================================================================
  // Elaboration checks
  // A port narrower than the map offsets would alias the two registers
  if (ADDR_W < $bits(`ALPG_WRITE_GUARD_ADDR)) begin : g_addr_narrow
    $error("ADDR_W too narrow for the register map");
  end
  // The two registers must sit at distinct offsets for the decode to work
  if (`ALPG_LOSS_ALARM_PIN_CONFIG_ADDR == `ALPG_WRITE_GUARD_ADDR) begin : g_addr_clash
    $error("register map offsets overlap");
  end

  // ========================================================================
  // Functions

  // Address match against a map offset widened to the port width
  function automatic logic addr_hit(input logic [ADDR_W-1:0] addr,
    input logic [ADDR_W-1:0] offset);
    addr_hit = (addr == offset);
  endfunction

  // Decode of the write-guard code; every code but the two open ones locks
  function automatic alpg_pkg::alpg_mode_type guard_decode(input logic [7:0] code);
    if (code == `ALPG_GUARD_OPEN) begin
      guard_decode = alpg_pkg::ALPG_UNPROTECTED;
    end else if (code == `ALPG_GUARD_SINGLE) begin
      guard_decode = alpg_pkg::ALPG_SINGLE_WRITE;
    end else begin
      // Codes below the open code lock as well, so a stray zero is safe
      guard_decode = alpg_pkg::ALPG_PROTECTED;
    end
  endfunction

  // Read view of the two registers; unmapped addresses read as zero
  function automatic logic [7:0] read_view(input logic cfg_sel, input logic guard_sel,
    input logic [7:0] cfg, input logic [7:0] guard);
    if (cfg_sel) begin
      read_view = cfg;
    end else if (guard_sel) begin
      read_view = guard;
    end else begin
      read_view = `ALPG_UNMAPPED_RDATA;
    end
  endfunction

  // Pin level in alarm role; idle is the inverse of the active level
  function automatic logic alarm_level(input logic active, input logic [7:0] cfg);
    alarm_level = active ~^ cfg[`ALPG_ACTIVE_LEVEL_BIT];
  endfunction

  // Pin enable in alarm role; a floating idle pin lets several sources share a line
  function automatic logic alarm_drive(input logic active, input logic [7:0] cfg);
    alarm_drive = active || !cfg[`ALPG_FLOAT_IDLE_BIT];
  endfunction

  // ========================================================================
  // Internal state and decode
  logic [7:0] pin_config_reg;
  logic [7:0] pin_config_next;
  logic [7:0] write_guard_reg;
  logic [7:0] write_guard_next;
  logic [7:0] reg_rdata_next;
  logic hit_config;
  logic hit_guard;
  logic other_allowed;
  logic guard_write;
  logic config_write;
  logic other_write;
  logic single_used;
  logic pin_level_next;
  logic pin_drive_next;

  // Address decode, shared by the writes and the read view
  assign hit_config = addr_hit(reg_addr, ADDR_W'(`ALPG_LOSS_ALARM_PIN_CONFIG_ADDR));
  assign hit_guard = addr_hit(reg_addr, ADDR_W'(`ALPG_WRITE_GUARD_ADDR));

  // Protection state is a pure decode of the guard, so it cannot drift from it
  assign guard_mode = guard_decode(write_guard_reg);
  assign other_allowed = (guard_mode != alpg_pkg::ALPG_PROTECTED);

  // Write qualifiers; the guard is the one register that protection never gates
  assign guard_write = reg_wr && hit_guard;
  assign config_write = reg_wr && hit_config && other_allowed;
  assign other_write = reg_wr && !hit_guard && !hit_config && other_allowed;
  // Any non-guard write spends the allowance, even one to an empty address
  assign single_used = reg_wr && !hit_guard
    && guard_mode == alpg_pkg::ALPG_SINGLE_WRITE;

  // ========================================================================
  // Write-guard register
  // A guard write and a spent allowance exclude each other by address,
  // so the guard write is never lost to the automatic relock
  always_comb begin
    write_guard_next = write_guard_reg;
    if (guard_write) begin
      write_guard_next = reg_wdata;
    end else if (single_used) begin
      write_guard_next = `ALPG_GUARD_RELOCK;
    end
  end

  // Guard flop; comes out of reset fully open
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      write_guard_reg <= `ALPG_WRITE_GUARD_RST;
    end else begin
      write_guard_reg <= write_guard_next;
    end
  end

  // ========================================================================
  // Pin configuration register
  // All eight bits are kept so the unused five still read back
  always_comb begin
    pin_config_next = pin_config_reg;
    if (config_write) begin
      pin_config_next = reg_wdata;
    end
  end

  // Configuration flop
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pin_config_reg <= `ALPG_LOSS_ALARM_PIN_CONFIG_RST;
    end else begin
      pin_config_reg <= pin_config_next;
    end
  end

  // ========================================================================
  // Forwarded write to other registers
  // Registered so the rest of the device sees data from flops, one cycle late
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      other_wr <= 1'b0;
      other_addr <= '0;
      other_wdata <= '0;
    end else begin
      other_wr <= other_write;
      other_addr <= reg_addr;
      other_wdata <= reg_wdata;
    end
  end

  // ========================================================================
  // Read data
  // Taken on the read strobe and held until the next read
  always_comb begin
    reg_rdata_next = reg_rdata;
    if (reg_rd) begin
      reg_rdata_next = read_view(hit_config, hit_guard, pin_config_reg, write_guard_reg);
    end
  end

  // Read data flop
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= `ALPG_RDATA_RST;
    end else begin
      reg_rdata <= reg_rdata_next;
    end
  end

  // ========================================================================
  // Alarm pin driver
  // Registered so the pin never glitches while the configuration decodes
  always_comb begin
    if (pin_config_reg[`ALPG_GPO_SELECT_BIT]) begin
      pin_level_next = gpo_level;
      pin_drive_next = 1'b1;
    end else begin
      pin_level_next = alarm_level(alarm_active, pin_config_reg);
      pin_drive_next = alarm_drive(alarm_active, pin_config_reg);
    end
  end

  // Pin level flop
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      loss_alarm_pin <= `ALPG_PIN_LEVEL_RST;
    end else begin
      loss_alarm_pin <= pin_level_next;
    end
  end

  // Pin enable flop; the pin floats during reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      loss_alarm_pin_oe <= `ALPG_PIN_OE_RST;
    end else begin
      loss_alarm_pin_oe <= pin_drive_next;
    end
  end

endmodule

/* File: dv/alpg_top_asserts.sv */
// Checker for alpg_top: alarm pin, gated writes and write-guard modes.
// Sees only the top ports; keeps its own copy of the pin configuration.
module alpg_top_asserts #(
  parameter int ADDR_W = 7
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register access
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // Gated write
  input wire logic other_wr,
  input wire logic [ADDR_W-1:0] other_addr,
  input wire logic [7:0] other_wdata,
  // Alarm pin
  input wire logic alarm_active,
  input wire logic gpo_level,
  input wire logic loss_alarm_pin,
  input wire logic loss_alarm_pin_oe,
  // Protection state
  input wire alpg_pkg::alpg_mode_type guard_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  // ==========================================================================
  // Own copies of both registers, kept from the rules alone
  logic [7:0] cfg, grd;
  logic op, po, pe, gw;
  assign op = grd == 8'h85 || grd == 8'h86;
  assign po = loss_alarm_pin;
  assign pe = loss_alarm_pin_oe;
  assign gw = reg_wr && reg_addr == 7'h7e;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg <= 8'h02;
      grd <= 8'h85;
    end else begin
      if (reg_wr && reg_addr == 7'h7d && op) cfg <= reg_wdata;
      if (gw) grd <= reg_wdata;
      else if (reg_wr && grd == 8'h86) grd <= 8'h87;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_gpo_drive: assert property (cfg[2] |=> pe && po == $past(gpo_level))
    else $error("gpo pin wrong");
  chk_alarm_lvl: assert property (!cfg[2] && alarm_active |=> pe && po == $past(cfg[0]))
    else $error("active level wrong");
  chk_idle_float: assert property (!cfg[2] && !alarm_active |=> pe == !$past(cfg[1]))
    else $error("idle drive wrong");
  chk_idle_lvl: assert property (!cfg[2] && !alarm_active && !cfg[1] |=> po == !$past(cfg[0]))
    else $error("idle level wrong");
  chk_pass_thru: assert property (reg_wr && op && !(reg_addr inside {7'h7d, 7'h7e}) |=>
    other_wr && other_addr == $past(reg_addr) && other_wdata == $past(reg_wdata))
    else $error("open write lost");
  chk_lock_drop: assert property (reg_wr && !op |=> !other_wr)
    else $error("blocked write passed");
  chk_single_use: assert property (reg_wr && !gw && grd == 8'h86
    |=> guard_mode == alpg_pkg::ALPG_PROTECTED) else $error("no relock");
  chk_guard_open: assert property (gw && reg_wdata == 8'h85
    |=> guard_mode == alpg_pkg::ALPG_UNPROTECTED) else $error("open code ignored");
  chk_guard_lock: assert property (gw && !(reg_wdata inside {8'h85, 8'h86})
    |=> guard_mode == alpg_pkg::ALPG_PROTECTED) else $error("lock code ignored");
  chk_mode_track: assert property (guard_mode == (grd == 8'h85 ?
    alpg_pkg::ALPG_UNPROTECTED : grd == 8'h86 ? alpg_pkg::ALPG_SINGLE_WRITE :
    alpg_pkg::ALPG_PROTECTED)) else $error("guard mode off");
  chk_cfg_read: assert property (reg_rd && reg_addr == 7'h7d
    |=> reg_rdata == $past(cfg)) else $error("config read wrong");
  chk_guard_read: assert property (reg_rd && reg_addr == 7'h7e
    |=> reg_rdata == $past(grd)) else $error("guard read wrong");
endmodule
bind alpg_top alpg_top_asserts #(.ADDR_W(ADDR_W)) u_alpg_top_asserts (.*);

/* File: dv/alpg_top_test.sv */
// Testbench for the alarm pin configuration and write-guard block.
// Drives the register port and alarm inputs itself; the checker is bound.
module alpg_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, alarm_active = 1'b0;
  logic gpo_level = 1'b0, pa, pg, pr;
  logic [6:0] reg_addr = 0, other_addr;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, other_wdata, n_ow = 8'h00, n, g, d, c = 8'h02, pc;
  logic other_wr, pin_o, pin_oe;
  alpg_pkg::alpg_mode_type guard_mode;
  int num_errors = 0, total_checks = 0, cycles = 0;
  integer seed = 32'h4b31, r, q;
  logic [7:0] codes [6] = '{8'h00, 8'h84, 8'h85, 8'h87, 8'hff, 8'h86};
  alpg_top u_alpg_top (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .other_wr(other_wr),
    .other_addr(other_addr), .other_wdata(other_wdata), .alarm_active(alarm_active),
    .gpo_level(gpo_level), .loss_alarm_pin(pin_o), .loss_alarm_pin_oe(pin_oe),
    .guard_mode(guard_mode));
  initial forever #5 clk = ~clk;
  // Random alarm and level each cycle; count gated pulses; check the pin; cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (other_wr === 1'b1) n_ow++;
    pa = alarm_active;
    pg = gpo_level;
    pr = rstn;
    pc = c;
    #1 q = $random(seed);
    if (pr) chk({6'h00, pin_oe, pin_oe && pin_o}, pin_exp(pc, pa, pg));
    alarm_active = q[0];
    gpo_level = q[1];
    if (cycles > 2000) begin
      num_errors++;
      complete_run();
    end
  end
  // ==========================================================================
  // Bus tasks and comparison
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] v);
    @(posedge clk);
    #1 reg_wr = 1;
    reg_addr = a;
    reg_wdata = v;
    @(posedge clk);
    #1 reg_wr = 0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    @(posedge clk);
    #1 reg_rd = 1;
    reg_addr = a;
    @(posedge clk);
    #1 reg_rd = 0;
    chk(reg_rdata, e);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  function automatic logic opens(input logic [7:0] v);
    return v == 8'h85 || v == 8'h86;
  endfunction
  // Pin enable and level; the level only matters while the pin is driven
  function automatic logic [7:0] pin_exp(input logic [7:0] cf, input logic al, input logic gp);
    logic oe;
    oe = cf[2] || al || !cf[1];
    return {6'h00, oe, oe && (cf[2] ? gp : al == cf[0])};
  endfunction
  // ==========================================================================
  // Main sequence: corner guard codes first, then random ones
  initial begin
    repeat (8) @(posedge clk);
    #1 rstn = 1;
    rd(7'h7d, 8'h02);
    rd(7'h7e, 8'h85);
    rd(7'h33, 8'h00);
    // Every mix of the three used bits, random unused bits above them
    for (int v = 0; v < 8; v++) begin
      r = $random(seed);
      d = {r[4:0], v[2:0]};
      wr(7'h7e, 8'h85);
      wr(7'h7d, d);
      c = d;
      rd(7'h7d, c);
      repeat (4) @(posedge clk);
    end
    for (int k = 0; k < 30; k++) begin
      r = $random(seed);
      g = (k < 6) ? codes[k] : r[7:0];
      d = r[15:8];
      n = n_ow;
      wr(7'h7e, g);
      wr(7'h7d, d);
      if (opens(g)) c = d;
      rd(7'h7d, c);
      wr(7'h33, d);
      rd(7'h7e, (g == 8'h86) ? 8'h87 : g);
      chk(n_ow - n, {7'h0, g == 8'h85});
    end
    n = n_ow;
    wr(7'h7e, 8'h86);
    wr(7'h7e, 8'h86);
    wr(7'h40, d);
    wr(7'h41, d);
    rd(7'h7e, 8'h87);
    chk(n_ow - n, 8'h01);
    complete_run();
  end
endmodule
